// ### hdl/acrs_channel.sv
/*
 * One converter channel: control, routing, interrupt flag, formatted result
 * with coherent byte reads, and automatic input scan, behind a Wishbone
 * classic slave with 32-bit data.
 * Assumes the analog core reports each finished conversion as a one-cycle
 * done strobe with its raw value, and the interrupt controller pulses
 * vector_taken when the channel vector starts executing.
 */
// Local design decision: the Wishbone slave port.
// Notes on behaviour
// - Finished conversion sets done flag normally
// - Compare mode sets flag only on condition
// - Vector execution clears the done flag
// - Writing one clears flag; zero keeps it
// - Signed results are two's complement
// - Result is 16 bits over two bytes
// - Left adjusted: high 11:4, low 3:0 on top
// - Right adjusted: bits 11:8 in high byte's low nibble
// - Right or 8-bit: bits 7:0 in low
// - Right adjusted high nibble sign-extends when differential
// - 8-bit high byte sign-extends when signed
// - Nonzero scan span enables scanning
// - Scan mux setting is selection plus step
// - Step increments after each conversion
// - Step wraps to zero after reaching span
// - Scan covers span plus one inputs
// - Single interrupt vector serves channel zero
// - Condition select: complete, below, reserved, above
// - Nonzero priority raises request while flag set
// - Signedness select governs 8-bit sign extension
`timescale 1ns/1ps
`default_nettype none

module acrs_channel
(
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic                     signedness_select,
	input  wire acrs_pkg::acrs_res_t      resolution,
	input  wire logic [15:0]              compare_value,
	input  wire acrs_pkg::acrs_conv_t     conv,
	input  wire logic                     vector_taken,
	output logic                          conv_start,
	output acrs_pkg::acrs_mux_t           mux,
	output logic      [2:0]               gain,
	output logic      [1:0]               input_mode,
	output logic                          irq_req,
	output logic      [1:0]               irq_priority
);
	import acrs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Register state

	logic        start_pending;
	logic [2:0]  gain_sel;
	logic [1:0]  mode_sel;
	logic [3:0]  positive_input_select;
	logic [2:0]  negative_input_select;
	logic [1:0]  irq_condition_select;
	logic [1:0]  irq_level;
	logic        done_flag;
	logic [15:0] combined_result;
	logic [7:0]  high_shadow;
	logic [3:0]  scan_step;
	logic [3:0]  scan_span;

	logic [15:0] next_result;
	logic        cond_met;
	logic        scan_on;
	logic        access;
	logic        wr;
	logic        rd;
	logic        mapped;
	logic [2:0]  index;
	logic [7:0]  wdata;
	logic [7:0]  rdata;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode

	assign index  = wb_adr_i[4:2];
	assign mapped = (wb_adr_i[7:5] == 3'h0) && (wb_adr_i[1:0] == 2'h0) && (index != 3'h7);
	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr     = access && wb_we_i && wb_sel_i[0] && mapped;
	assign rd     = access && !wb_we_i && mapped;
	assign wdata  = wb_dat_i[7:0];

	function automatic logic hit(input logic [2:0] idx, input logic [2:0] reg_idx);
		hit = idx == reg_idx;
	endfunction

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= access;
	end

	always_comb
	begin
		rdata = 8'h00;
		unique case (index)
			REG_CHANNEL_CONTROL:
				rdata = {start_pending, 2'b00, gain_sel, mode_sel};
			REG_INPUT_ROUTING:
				rdata = {1'b0, positive_input_select, negative_input_select};
			REG_IRQ_SETUP:
				rdata = {4'h0, irq_condition_select, irq_level};
			REG_IRQ_FLAGS:
				rdata = {7'h00, done_flag};
			REG_RESULT_LOW:
				rdata = combined_result[7:0];
			REG_RESULT_HIGH:
				rdata = high_shadow;
			REG_SCAN_SETUP:
				rdata = {scan_step, scan_span};
			default:
				rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			wb_dat_o <= 32'h0000_0000;
		else if (access)
			wb_dat_o <= mapped ? {24'h00_0000, rdata} : 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////////
	// Control, routing and interrupt setup

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			start_pending <= CONTROL_RESET[CTRL_START_BIT];
			gain_sel      <= CONTROL_RESET[CTRL_GAIN_LSB +: 3];
			mode_sel      <= CONTROL_RESET[1:0];
		end
		else
		begin
			if (wr && hit(index, REG_CHANNEL_CONTROL))
			begin
				gain_sel <= wdata[CTRL_GAIN_LSB +: 3];
				mode_sel <= wdata[1:0];
			end
			if (wr && hit(index, REG_CHANNEL_CONTROL) && wdata[CTRL_START_BIT])
				start_pending <= 1'b1;
			else if (conv.done)
				start_pending <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			conv_start <= 1'b0;
		else
			conv_start <= wr && hit(index, REG_CHANNEL_CONTROL) && wdata[CTRL_START_BIT];
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			positive_input_select <= ROUTING_RESET[ROUTE_POS_LSB +: 4];
			negative_input_select <= ROUTING_RESET[2:0];
		end
		else if (wr && hit(index, REG_INPUT_ROUTING))
		begin
			positive_input_select <= wdata[ROUTE_POS_LSB +: 4];
			negative_input_select <= wdata[2:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			irq_condition_select <= SETUP_RESET[SETUP_COND_LSB +: 2];
			irq_level            <= SETUP_RESET[1:0];
		end
		else if (wr && hit(index, REG_IRQ_SETUP))
		begin
			irq_condition_select <= wdata[SETUP_COND_LSB +: 2];
			irq_level            <= wdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result formatting, compare and done flag

	acrs_formatter u_formatter
	(
		.raw                  (conv.value),
		.resolution           (resolution),
		.signedness_select    (signedness_select),
		.differential         (mode_sel[1]),
		.compare_value        (compare_value),
		.irq_condition_select (irq_condition_select),
		.combined_result      (next_result),
		.cond_met             (cond_met)
	);

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			combined_result <= RESULT_RESET;
		else if (conv.done)
			combined_result <= next_result;
	end

	// Low read freezes the high byte for the following high read
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			high_shadow <= RESULT_RESET[15:8];
		else if (rd && hit(index, REG_RESULT_LOW))
			high_shadow <= combined_result[15:8];
	end

	// Set wins over either clear
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			done_flag <= 1'b0;
		else if (conv.done && cond_met)
			done_flag <= 1'b1;
		else if (vector_taken)
			done_flag <= 1'b0;
		else if (wr && hit(index, REG_IRQ_FLAGS) && wdata[FLAG_DONE_BIT])
			done_flag <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			irq_req      <= 1'b0;
			irq_priority <= 2'b00;
		end
		else
		begin
			irq_req      <= done_flag && (irq_level != 2'b00);
			irq_priority <= irq_level;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Input scan

	assign scan_on = scan_span != 4'h0;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			scan_step <= SCAN_RESET;
			scan_span <= SCAN_RESET;
		end
		else if (wr && hit(index, REG_SCAN_SETUP))
		begin
			scan_step <= wdata[SCAN_STEP_LSB +: 4];
			scan_span <= wdata[3:0];
		end
		else if (conv.done && scan_on)
		begin
			if (scan_step == scan_span)
				scan_step <= 4'h0;
			else
				scan_step <= 4'(scan_step + 4'h1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			mux        <= '0;
			gain       <= 3'h0;
			input_mode <= 2'h0;
		end
		else
		begin
			mux.pos    <= scan_on ? 4'(positive_input_select + scan_step)
				: positive_input_select;
			mux.neg    <= negative_input_select;
			gain       <= gain_sel;
			input_mode <= mode_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_flag_write(logic one);
		wr && hit(index, REG_IRQ_FLAGS) && (wdata[FLAG_DONE_BIT] == one);
	endsequence

	sequence s_quiet;
		!conv.done && !vector_taken;
	endsequence

	AST_FLAG_SETS:
	assert property (conv.done && irq_condition_select == COND_COMPLETE |=> done_flag)
		else $error("Done flag not set after completed conversion");

	AST_RESERVED_COND_NO_SET:
	assert property (conv.done && irq_condition_select == COND_RESERVED && !done_flag
		|=> !done_flag)
		else $error("Done flag set under reserved condition");

	AST_VECTOR_CLEARS:
	assert property (vector_taken && !conv.done |=> !done_flag)
		else $error("Vector execution did not clear done flag");

	AST_W1C:
	assert property (s_flag_write(1'b1) and s_quiet |=> !done_flag ##1 wb_ack_o == 1'b0)
		else $error("Writing one did not clear done flag");

	AST_W0_KEEPS:
	assert property (s_flag_write(1'b0) and s_quiet and done_flag |=> done_flag)
		else $error("Writing zero changed done flag");

	AST_SCAN_INC:
	assert property (conv.done && scan_on && scan_step != scan_span && !wr
		|=> scan_step == 4'($past(scan_step) + 4'h1))
		else $error("Scan step did not advance");

	AST_SCAN_WRAP:
	assert property (conv.done && scan_on && scan_step == scan_span && !wr |=> scan_step == 4'h0)
		else $error("Scan step did not wrap");

	AST_SCAN_OFF:
	assert property (conv.done && !scan_on && !wr |=> $stable(scan_step))
		else $error("Scan step moved while scan disabled");

	AST_MUX_SUM:
	assert property (scan_on && !wr |=> mux.pos == 4'($past(positive_input_select)
		+ $past(scan_step)))
		else $error("Scan mux setting is not selection plus step");

	AST_IRQ_REQ:
	assert property (done_flag && irq_level != 2'b00 |=> irq_req)
		else $error("Interrupt request missing while flag set");

	AST_SHADOW:
	assert property (rd && hit(index, REG_RESULT_LOW) |=> high_shadow == $past(combined_result[15:8]))
		else $error("High byte not captured on low read");

endmodule

`default_nettype wire

// ### hdl/acrs_formatter.sv
/*
 * Result formatter: packs a raw conversion into the 16-bit combined result
 * and evaluates the compare condition on it. Purely combinational; the
 * caller registers its outputs.
 */
`timescale 1ns/1ps
`default_nettype none

module acrs_formatter
(
	input  wire logic [11:0]              raw,
	input  wire acrs_pkg::acrs_res_t      resolution,
	input  wire logic                     signedness_select,
	input  wire logic                     differential,
	input  wire logic [15:0]              compare_value,
	input  wire logic [1:0]               irq_condition_select,
	output logic      [15:0]              combined_result,
	output logic                          cond_met
);
	import acrs_pkg::*;

	logic result_bit_eleven;
	logic result_bit_seven;

	assign result_bit_eleven = raw[11];
	assign result_bit_seven  = raw[7];

	always_comb
	begin
		unique case (resolution)
			ACRS_RES_12_LEFT:
				combined_result = {raw[11:4], raw[3:0], 4'h0};
			ACRS_RES_8:
				combined_result = {{8{signedness_select & result_bit_seven}}, raw[7:0]};
			default:
				combined_result = {{4{differential & result_bit_eleven}}, raw[11:0]};
		endcase
	end

	always_comb
	begin
		unique case (irq_condition_select)
			COND_COMPLETE:
				cond_met = 1'b1;
			COND_BELOW:
				cond_met = acrs_less(combined_result, compare_value, signedness_select);
			COND_ABOVE:
				cond_met = acrs_less(compare_value, combined_result, signedness_select);
			default:
				cond_met = 1'b0;
		endcase
	end

endmodule

`default_nettype wire

// ### hdl/acrs_pkg.sv
/*
 * Shared constants and types of the converter channel result and scan logic.
 * Assumes a byte-wide register map reached as one 32-bit Wishbone word each.
 */
package acrs_pkg;

	// Register indices; byte address is four times the index
	localparam logic [2:0] REG_CHANNEL_CONTROL = 3'h0;
	localparam logic [2:0] REG_INPUT_ROUTING   = 3'h1;
	localparam logic [2:0] REG_IRQ_SETUP       = 3'h2;
	localparam logic [2:0] REG_IRQ_FLAGS       = 3'h3;
	localparam logic [2:0] REG_RESULT_LOW      = 3'h4;
	localparam logic [2:0] REG_RESULT_HIGH     = 3'h5;
	localparam logic [2:0] REG_SCAN_SETUP      = 3'h6;

	// Field positions
	localparam int CTRL_START_BIT  = 7;
	localparam int CTRL_GAIN_LSB   = 2;
	localparam int ROUTE_POS_LSB   = 3;
	localparam int SETUP_COND_LSB  = 2;
	localparam int FLAG_DONE_BIT   = 0;
	localparam int SCAN_STEP_LSB   = 4;

	// Values after reset
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [6:0]  ROUTING_RESET = 7'h00;
	localparam logic [3:0]  SETUP_RESET   = 4'h0;
	localparam logic [15:0] RESULT_RESET  = 16'h0000;
	localparam logic [3:0]  SCAN_RESET    = 4'h0;

	// Flag-setting conditions
	localparam logic [1:0] COND_COMPLETE = 2'b00;
	localparam logic [1:0] COND_BELOW    = 2'b01;
	localparam logic [1:0] COND_RESERVED = 2'b10;
	localparam logic [1:0] COND_ABOVE    = 2'b11;

	typedef enum logic [1:0] {
		ACRS_RES_12_RIGHT,
		ACRS_RES_8,
		ACRS_RES_12_LEFT
	} acrs_res_t;

	typedef struct packed {
		logic        done;
		logic [11:0] value;
	} acrs_conv_t;

	typedef struct packed {
		logic [3:0] pos;
		logic [2:0] neg;
	} acrs_mux_t;

	// Sign-aware strict compare of two 16-bit words
	function automatic logic acrs_less(input logic [15:0] a, input logic [15:0] b,
		input logic signed_mode);
		if (signed_mode)
			acrs_less = $signed(a) < $signed(b);
		else
			acrs_less = a < b;
	endfunction

endpackage

// ### testbench/acrs_channel_bench.sv
/*
 * Self-checking bench of the converter channel: result formatting,
 * done flag, compare modes, input scan and register access.
 * Assumes acrs_pkg and acrs_channel are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module acrs_channel_bench;
	import acrs_pkg::*;

	logic        clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        signedness_select, vector_taken, conv_start, irq_req;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [15:0] compare_value;
	logic [2:0]  gain;
	logic [1:0]  input_mode, irq_priority;
	acrs_res_t   resolution;
	acrs_conv_t  conv;
	acrs_mux_t   mux;
	logic [32:0] expq[$];
	logic [32:0] note;
	int          fails, n_checks, starts;

	acrs_channel dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .signedness_select(signedness_select),
		.resolution(resolution), .compare_value(compare_value), .conv(conv),
		.vector_taken(vector_taken), .conv_start(conv_start), .mux(mux),
		.gain(gain), .input_mode(input_mode), .irq_req(irq_req),
		.irq_priority(irq_priority));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Start pulses seen on the converter side
	always @(posedge clk)
		if (conv_start === 1'b1)
			starts++;

	// Read data is judged when ack appears
	always @(posedge clk)
		if (wb_ack_o === 1'b1)
		begin
			if (expq.size() == 0)
				check("unexpected ack", 32'h1, 32'h0);
			else
			begin
				note = expq.pop_front();
				if (note[32])
					check("read data", wb_dat_o, note[31:0]);
			end
		end

	////////////////////////////////////////////////////////////////////////
	task automatic wb_access(input logic [7:0] a, input logic w, input logic [7:0] d,
		input logic [32:0] n);
		int i;
		expq.push_back(n);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h0, d};
		i = 0;
		@(posedge clk);
		while (wb_ack_o !== 1'b1 && i < 20)
		begin
			@(posedge clk);
			i++;
		end
		if (wb_ack_o !== 1'b1)
		begin
			fails++;
			report_and_stop();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb_access(a, 1'b1, d, 33'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		wb_access(a, 1'b0, 8'h00, {9'h100, 16'h0, e});
	endtask

	task automatic convert(input logic [11:0] v);
		conv <= '{done: 1'b1, value: v};
		@(posedge clk);
		conv <= '{done: 1'b0, value: ~v};
		@(posedge clk);
		@(posedge clk);
	endtask

	function automatic logic [15:0] fmt(input logic [11:0] v, input int r, input logic s,
		input logic d);
		case (r)
			0: fmt = {d ? {4{v[11]}} : 4'h0, v};
			1: fmt = {s ? {8{v[7]}} : 8'h00, v[7:0]};
			default: fmt = {v, 4'h0};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [11:0] a, b;
		logic [15:0] e;
		logic [1:0]  c;
		logic [2:0]  g;
		logic        s, d;
		int          k, r;
		{reset_n, wb_cyc_i, wb_stb_i, wb_we_i, signedness_select, vector_taken} = '0;
		{wb_adr_i, wb_sel_i, wb_dat_i, compare_value} = '0;
		resolution = ACRS_RES_12_RIGHT;
		conv = '0;
		void'($urandom(55053));
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(8'h18, 8'h00);
		rd(8'h0c, 8'h00);
		rd(8'h14, 8'h00);
		// Formatting over every resolution and signedness
		wr(8'h08, 8'h01);
		for (k = 0; k < 12; k++)
		begin
			r = k % 3;
			s = 1'((k / 3) % 2);
			d = s & 1'($urandom);
			a = 12'($urandom);
			b = ~a;
			e = fmt(a, r, s, d);
			signedness_select <= s;
			resolution <= acrs_res_t'(r);
			g = 3'($urandom);
			wr(8'h00, {3'h0, g, d, 1'b1});
			rd(8'h00, {3'h0, g, d, 1'b1});
			check("gain", 32'(gain), 32'(g));
			check("input_mode", 32'(input_mode), 32'({d, 1'b1}));
			convert(a);
			check("irq_req", 32'(irq_req), 32'h1);
			check("irq_priority", 32'(irq_priority), 32'h1);
			rd(8'h10, e[7:0]);
			convert(b);
			rd(8'h14, e[15:8]);
			rd(8'h0c, 8'h01);
			if (k[0])
			begin
				wr(8'h0c, 8'h00);
				rd(8'h0c, 8'h01);
				wr(8'h0c, 8'h01);
			end
			else
			begin
				vector_taken <= 1'b1;
				@(posedge clk);
				vector_taken <= 1'b0;
				@(posedge clk);
			end
			rd(8'h0c, 8'h00);
			check("irq_req", 32'(irq_req), 32'h0);
		end
		// Every condition select with results below and above the threshold
		signedness_select <= 1'b0;
		resolution <= ACRS_RES_12_RIGHT;
		compare_value <= 16'h0800;
		wr(8'h00, 8'h81);
		rd(8'h00, 8'h81);
		for (k = 0; k < 8; k++)
		begin
			c = 2'(k / 2);
			wr(8'h08, {4'h0, c, 2'b01});
			convert(k[0] ? 12'hf00 : 12'h100);
			rd(8'h0c, {7'h0, c == 2'b00 || (c == 2'b01 && !k[0]) || (c == 2'b11 && k[0])});
			wr(8'h0c, 8'h01);
		end
		check("conv_start pulses", 32'(starts), 32'h1);
		rd(8'h00, 8'h01);
		// Signed compare: a negative result lies below zero
		signedness_select <= 1'b1;
		compare_value <= 16'h0000;
		wr(8'h00, 8'h02);
		wr(8'h08, 8'h05);
		convert(12'hf00);
		rd(8'h0c, 8'h01);
		wr(8'h0c, 8'h01);
		// Scan over three inputs from selection five
		wr(8'h04, 8'h2b);
		wr(8'h18, 8'h02);
		check("mux pos", 32'(mux.pos), 32'h5);
		check("mux neg", 32'(mux.neg), 32'h3);
		for (k = 1; k < 5; k++)
		begin
			convert(12'h000);
			check("mux pos", 32'(mux.pos), 32'(5 + k % 3));
			rd(8'h18, {4'(k % 3), 4'h2});
		end
		wr(8'h18, 8'h00);
		convert(12'h000);
		check("mux pos", 32'(mux.pos), 32'h5);
		// Unmapped place and read-only result
		rd(8'h1c, 8'h00);
		wr(8'h10, 8'hff);
		rd(8'h10, 8'h00);
		report_and_stop();
	end
endmodule

`default_nettype wire
